// >>> hw/cac_pkg.sv
// Constants shared by the counter array control block
// Functional notes
// - Overflow flag sets when counter rolls from 0xffff to 0x0000; only software clears it.
// - Overflow flag requests an interrupt only while its enable bit is one.
// - Counter advances only while the run bit is one, otherwise holds.
// - Each module event sets that module's flag, held until software clears it.
// - A set module flag with its enable high raises the shared request.
// - With idle suspend set, counting stops while the CPU idles.
// - A 3-bit select picks one of seven tick sources; code 111 is reserved.
// - Control register is bit-addressable; single bits change without touching others.
// - Cycle wrap flag sets when the selected 8 to 11 bit span overflows.
// - Cycle wrap flag with its enable high raises the shared request.
// - Cycle length codes 000 to 011 give 8 to 11 bits; others reserved.
// - Reload select steers compare register accesses to reload or compare registers.
package cac_pkg;
  // Register addresses
  localparam logic [7:0] CAC_ADDR_CTL  = 8'hd8;
  localparam logic [7:0] CAC_ADDR_MODE = 8'hd9;
  localparam logic [7:0] CAC_ADDR_PWM  = 8'hf7;
  // Reset values
  localparam logic [7:0] CAC_CTL_RST   = 8'h00;
  localparam logic [7:0] CAC_MODE_RST  = 8'h00;
  localparam logic [7:0] CAC_PWM_RST   = 8'h00;
  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] CAC_CTL_MASK  = 8'hc7;
  localparam logic [7:0] CAC_MODE_MASK = 8'h8f;
  localparam logic [7:0] CAC_PWM_MASK  = 8'he7;
  // Control register fields
  localparam int CAC_CTL_OVF  = 7;
  localparam int CAC_CTL_RUN  = 6;
  localparam int CAC_CTL_EVT0 = 0;
  // Mode register fields
  localparam int CAC_MODE_IDLE  = 7;
  localparam int CAC_MODE_SEL_L = 1;
  localparam int CAC_MODE_OVFEN = 0;
  // Pwm configuration fields
  localparam int CAC_PWM_RELOAD = 7;
  localparam int CAC_PWM_WRAPEN = 6;
  localparam int CAC_PWM_WRAP   = 5;
  localparam int CAC_PWM_LEN_L  = 0;
  // Number of capture/compare modules
  localparam int CAC_NMOD = 3;
  // Prescaler figures
  localparam logic [3:0] CAC_DIV12_LAST = 4'hb;
  localparam logic [1:0] CAC_DIV4_LAST  = 2'h3;
  localparam logic [2:0] CAC_DIV8_LAST  = 3'h7;
  // Timebase codes
  typedef enum logic [2:0] {
    CAC_TB_DIV12 = 3'b000,
    CAC_TB_DIV4  = 3'b001,
    CAC_TB_T0OVF = 3'b010,
    CAC_TB_EXTFE = 3'b011,
    CAC_TB_SYS   = 3'b100,
    CAC_TB_EXT8  = 3'b101,
    CAC_TB_LFO8  = 3'b110,
    CAC_TB_RSVD  = 3'b111
  } cac_tb_t;
endpackage

// >>> hw/cac_tick.sv
// Timebase tick generator with pin synchronisers and prescalers
`timescale 1ns/1ps
module cac_tick
  import cac_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Control
  input  wire logic [2:0] sel,
  input  wire logic       active,
  // Sources
  input  wire logic       timer0_ovf,
  input  wire logic       external_count_input,
  input  wire logic       ext_clk_in,
  input  wire logic       lfo_clk_in,
  // Result
  output logic            tick
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [2:0] last_ff;
  logic [3:0] div_ff;
  logic [3:0] nxt_div;
  logic [1:0] d8_tick;
  logic       fall_eci;
  logic [2:0] pins;

  assign pins = {lfo_clk_in, ext_clk_in, external_count_input};

  // Two-stage synchronisers plus a history stage for edge detection
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
      last_ff <= 3'h0;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Falling edge on the count pin, one per qualifying transition
  assign fall_eci = last_ff[0] & ~sync_ff[0];

  // Divide by 8 on rising edges of the external and low-frequency clocks
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div8
      logic       rise;
      logic [2:0] d8_ff;
      assign rise       = sync_ff[g+1] & ~last_ff[g+1];
      assign d8_tick[g] = rise & (d8_ff == CAC_DIV8_LAST);
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          d8_ff <= 3'h0;
        end else if (rise && active) begin
          d8_ff <= d8_ff + 3'h1;
        end
      end
    end
  endgenerate

  // System clock prescaler, 12 states; divide by 4 taps its low bits
  assign nxt_div = (div_ff == CAC_DIV12_LAST) ? 4'h0 : div_ff + 4'h1;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 4'h0;
    end else if (active) begin
      div_ff <= nxt_div;
    end
  end

  // Source selection
  always_comb begin
    unique case (cac_tb_t'(sel))
      CAC_TB_DIV12: tick = (div_ff == CAC_DIV12_LAST);
      CAC_TB_DIV4:  tick = (div_ff[1:0] == CAC_DIV4_LAST);
      CAC_TB_T0OVF: tick = timer0_ovf;
      CAC_TB_EXTFE: tick = fall_eci;
      CAC_TB_SYS:   tick = 1'b1;
      CAC_TB_EXT8:  tick = d8_tick[0];
      CAC_TB_LFO8:  tick = d8_tick[1];
      CAC_TB_RSVD:  tick = 1'b0;
    endcase
  end
endmodule

// >>> hw/cac_top.sv
// Counter array control: run, timebase, flags, interrupt and register access
`timescale 1ns/1ps
module cac_top
  import cac_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // Special function register bus
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_rd,
  output logic      [7:0]          sfr_rdata,
  // Single-bit access to the control register
  input  wire logic                bit_wr,
  input  wire logic [2:0]          bit_idx,
  input  wire logic                bit_val,
  // Events from the modules and the core
  input  wire logic [CAC_NMOD-1:0] module_event,
  input  wire logic [CAC_NMOD-1:0] module_event_irq_enable,
  input  wire logic                cpu_idle,
  input  wire logic                timer0_ovf,
  // Pins
  input  wire logic                external_count_input,
  input  wire logic                ext_clk_in,
  input  wire logic                lfo_clk_in,
  // Results
  output logic      [15:0]         counter_value,
  output logic      [2:0]          cycle_length,
  output logic                     reload_select,
  output logic                     irq
);
  logic [7:0]  ctl_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  pwm_ff;
  logic [15:0] cnt_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_ctl;
  logic [7:0]  nxt_mode;
  logic [7:0]  nxt_pwm;
  logic [7:0]  nxt_rdata;
  logic [15:0] nxt_cnt;
  logic [7:0]  ctl_sw;
  logic [7:0]  ctl_set;
  logic [7:0]  pwm_set;
  logic        wr_ctl;
  logic        wr_mode;
  logic        wr_pwm;
  logic        halt;
  logic        tick;
  logic        adv;
  logic        roll;
  logic        wrap;

  // Overflow out of the low 8 to 11 bits as picked by the length code
  function automatic logic span_wrap(input logic [2:0] len, input logic [15:0] c);
    logic r;
    r = 1'b0;
    unique case (len)
      3'b000:  r = &c[7:0];
      3'b001:  r = &c[8:0];
      3'b010:  r = &c[9:0];
      3'b011:  r = &c[10:0];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Address decode
  assign wr_ctl  = sfr_wr && (sfr_addr == CAC_ADDR_CTL);
  assign wr_mode = sfr_wr && (sfr_addr == CAC_ADDR_MODE);
  assign wr_pwm  = sfr_wr && (sfr_addr == CAC_ADDR_PWM);

  // Idle suspend and counting qualifier
  assign halt = mode_ff[CAC_MODE_IDLE] & cpu_idle;
  assign adv  = tick & ctl_ff[CAC_CTL_RUN] & ~halt;
  assign roll = adv & (cnt_ff == 16'hffff);
  assign wrap = adv & span_wrap(pwm_ff[CAC_PWM_LEN_L +: 3], cnt_ff);
  assign nxt_cnt = adv ? cnt_ff + 16'h0001 : cnt_ff;

  cac_tick u_tick (
    .sys_clk              (sys_clk),
    .nrst                 (nrst),
    .sel                  (mode_ff[CAC_MODE_SEL_L +: 3]),
    .active               (~halt),
    .timer0_ovf           (timer0_ovf),
    .external_count_input (external_count_input),
    .ext_clk_in           (ext_clk_in),
    .lfo_clk_in           (lfo_clk_in),
    .tick                 (tick)
  );

  // Control: byte write, else single-bit write, then hardware sets win
  assign ctl_sw  = wr_ctl ? (sfr_wdata & CAC_CTL_MASK)
                 : (bit_wr ? ((ctl_ff & ~(8'h01 << bit_idx))
                              | ({7'h00, bit_val} << bit_idx)) & CAC_CTL_MASK
                 : ctl_ff);
  assign ctl_set = {roll, 4'h0, module_event};
  assign nxt_ctl = ctl_sw | ctl_set;

  // Mode and pwm configuration
  assign nxt_mode = wr_mode ? (sfr_wdata & CAC_MODE_MASK) : mode_ff;
  assign pwm_set  = {2'h0, wrap, 5'h00};
  assign nxt_pwm  = (wr_pwm ? (sfr_wdata & CAC_PWM_MASK) : pwm_ff) | pwm_set;

  // Read data, unmapped addresses read zero
  assign nxt_rdata = !sfr_rd ? rdata_ff
                   : (sfr_addr == CAC_ADDR_CTL)  ? ctl_ff
                   : (sfr_addr == CAC_ADDR_MODE) ? mode_ff
                   : (sfr_addr == CAC_ADDR_PWM)  ? pwm_ff
                   : 8'h00;

  // State registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_ff   <= CAC_CTL_RST;
      mode_ff  <= CAC_MODE_RST;
      pwm_ff   <= CAC_PWM_RST;
      cnt_ff   <= 16'h0000;
      rdata_ff <= 8'h00;
    end else begin
      ctl_ff   <= nxt_ctl;
      mode_ff  <= nxt_mode;
      pwm_ff   <= nxt_pwm;
      cnt_ff   <= nxt_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs
  assign sfr_rdata     = rdata_ff;
  assign counter_value = cnt_ff;
  assign cycle_length  = pwm_ff[CAC_PWM_LEN_L +: 3];
  assign reload_select = pwm_ff[CAC_PWM_RELOAD];
  assign irq = (ctl_ff[CAC_CTL_OVF] & mode_ff[CAC_MODE_OVFEN])
             | (|(ctl_ff[CAC_NMOD-1:0] & module_event_irq_enable))
             | (pwm_ff[CAC_PWM_WRAP] & pwm_ff[CAC_PWM_WRAPEN]);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Overflow flag
  chk_ovf_sets: assert property (
    roll |=> ctl_ff[CAC_CTL_OVF] && cnt_ff == 16'h0000)
    else $error("overflow flag not set on rollover");
  chk_ovf_sticky: assert property (
    ctl_ff[CAC_CTL_OVF] && !wr_ctl && !(bit_wr && bit_idx == 3'h7) |=> ctl_ff[CAC_CTL_OVF])
    else $error("overflow flag cleared without software");
  chk_ovf_masked: assert property (
    (!mode_ff[CAC_MODE_OVFEN] && ctl_ff[2:0] == 3'h0 && !pwm_ff[CAC_PWM_WRAP]) |-> !irq)
    else $error("request raised with overflow interrupt disabled");
  chk_ovf_irq: assert property (
    ctl_ff[CAC_CTL_OVF] && mode_ff[CAC_MODE_OVFEN] |-> irq)
    else $error("enabled overflow flag gave no request");

  // Run control, idle suspend and timebase
  chk_stop_holds: assert property (!ctl_ff[CAC_CTL_RUN] |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while stopped");
  chk_idle_freeze: assert property (
    (mode_ff[CAC_MODE_IDLE] && cpu_idle)[*2] |=> cnt_ff == $past(cnt_ff, 2))
    else $error("counter moved while suspended in idle");
  chk_sysclk_tick: assert property (
    (ctl_ff[CAC_CTL_RUN] && !halt && mode_ff[3:1] == 3'b100) |=>
    cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("system clock timebase did not count every cycle");
  chk_rsvd_tb: assert property (
    mode_ff[3:1] == 3'b111 |=> cnt_ff == $past(cnt_ff))
    else $error("reserved timebase code advanced the counter");
  chk_count_step: assert property (adv |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter step wrong");

  // Module flags and the shared request
  chk_event_flag: assert property (
    module_event != 3'h0 |=> (ctl_ff[2:0] & $past(module_event)) == $past(module_event))
    else $error("module flag missed its event");
  chk_event_sticky: assert property (
    !wr_ctl && !bit_wr |=> (ctl_ff[2:0] & $past(ctl_ff[2:0])) == $past(ctl_ff[2:0]))
    else $error("module flag cleared without software");
  chk_module_irq: assert property (
    (ctl_ff[2:0] & module_event_irq_enable) != 3'h0 |-> irq)
    else $error("enabled module flag gave no request");
  chk_irq_level: assert property (
    irq && ctl_ff == $past(ctl_ff) && pwm_ff == $past(pwm_ff) && mode_ff == $past(mode_ff)
    && $stable(module_event_irq_enable) |-> $past(irq))
    else $error("request changed with flags steady");

  // Register access
  chk_bit_set: assert property (
    (bit_wr && !wr_ctl && bit_idx == 3'h6 && bit_val) |=>
    ctl_ff[CAC_CTL_RUN] && ctl_ff[2:0] == ($past(ctl_ff[2:0]) | $past(module_event)))
    else $error("single-bit write disturbed other bits");
  chk_bit_rsvd: assert property (
    ctl_ff[5:3] == 3'h0)
    else $error("reserved control bits set");
  chk_byte_wins: assert property (
    wr_ctl && bit_wr |=> ctl_ff[CAC_CTL_RUN] == $past(sfr_wdata[CAC_CTL_RUN]))
    else $error("single-bit write beat a byte write");
  chk_reload_out: assert property (
    wr_pwm |=> reload_select == $past(sfr_wdata[CAC_PWM_RELOAD]))
    else $error("reload select did not follow its write");

  // Cycle wrap flag
  chk_wrap_flag: assert property (wrap |=> pwm_ff[CAC_PWM_WRAP])
    else $error("cycle wrap flag missed");
  chk_wrap_sticky: assert property (
    pwm_ff[CAC_PWM_WRAP] && !wr_pwm |=> pwm_ff[CAC_PWM_WRAP])
    else $error("cycle wrap flag cleared without software");
  chk_wrap_irq: assert property (
    pwm_ff[CAC_PWM_WRAP] && pwm_ff[CAC_PWM_WRAPEN] |-> irq)
    else $error("cycle wrap request missing");
  chk_len8_wrap: assert property (
    (adv && pwm_ff[2:0] == 3'b000 && cnt_ff[7:0] == 8'hff) |=> pwm_ff[CAC_PWM_WRAP])
    else $error("8-bit cycle length misdecoded");
  chk_len11_wrap: assert property (
    (adv && pwm_ff[2:0] == 3'b011 && cnt_ff[10:0] == 11'h7ff) |=> pwm_ff[CAC_PWM_WRAP])
    else $error("11-bit cycle length misdecoded");
  chk_rsvd_len: assert property (
    (pwm_ff[2] && !pwm_ff[CAC_PWM_WRAP] && !wr_pwm) |=> !pwm_ff[CAC_PWM_WRAP])
    else $error("reserved cycle length raised the wrap flag");

  cov_rollover: cover property (roll);
  cov_cycle_wrap: cover property (wrap ##1 irq);
  cov_idle_stop: cover property (ctl_ff[CAC_CTL_RUN] && halt);
  cov_event_irq: cover property (module_event[0] ##1 irq);
  cov_set_beats_clr: cover property (module_event[0] && wr_ctl && !sfr_wdata[0]);
endmodule

// >>> verification/cac_top_tb.sv
// Self-checking testbench for the counter array control block
`timescale 1ns/1ps
module cac_top_tb;
  import cac_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        bit_wr = 1'b0;
  logic [2:0]  bit_idx = 3'h0;
  logic        bit_val = 1'b0;
  logic [2:0]  module_event = 3'h0;
  logic [2:0]  module_event_irq_enable = 3'h0;
  logic        cpu_idle = 1'b0;
  logic        timer0_ovf = 1'b0;
  logic        external_count_input = 1'b0;
  logic        ext_clk_in = 1'b0;
  logic        lfo_clk_in = 1'b0;
  logic [15:0] counter_value;
  logic [2:0]  cycle_length;
  logic        reload_select;
  logic        irq;
  int          err_count = 0;
  int          num_checks = 0;

  // Design under test
  cac_top i_cac_top (
    .sys_clk(sys_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr),
    .bit_idx(bit_idx), .bit_val(bit_val), .module_event(module_event),
    .module_event_irq_enable(module_event_irq_enable), .cpu_idle(cpu_idle),
    .timer0_ovf(timer0_ovf), .external_count_input(external_count_input),
    .ext_clk_in(ext_clk_in), .lfo_clk_in(lfo_clk_in), .counter_value(counter_value),
    .cycle_length(cycle_length), .reload_select(reload_select), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic final_report;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Value and flag comparisons
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Bus cycles, driven just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    step(1);
    sfr_wr    = 1'b0;
    step(1);
  endtask
  task automatic bw(input int idx, input logic v);
    bit_idx = idx[2:0];
    bit_val = v;
    bit_wr  = 1'b1;
    step(1);
    bit_wr  = 1'b0;
    step(1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    step(1);
    sfr_rd   = 1'b0;
    chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
    step(1);
  endtask
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      step(1);
      n++;
    end
    if (irq !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask

  // Reset values, reserved bits, bit access, flag masking
  task automatic t_regs;
    rdchk(CAC_ADDR_CTL, CAC_CTL_RST);
    rdchk(8'ha5, 8'h00);
    wr(CAC_ADDR_MODE, 8'h8f);
    rdchk(CAC_ADDR_MODE, 8'h8f);
    wr(CAC_ADDR_PWM, 8'he7);
    rdchk(CAC_ADDR_PWM, 8'he7);
    chk_bit("irq", 1'b1, irq);
    chk("pwm_out", 16'h000f, {12'h000, reload_select, cycle_length});
    wr(CAC_ADDR_PWM, 8'h20);
    chk_bit("irq", 1'b0, irq);
    wr(CAC_ADDR_PWM, 8'h00);
    wr(CAC_ADDR_MODE, 8'h00);
    wr(CAC_ADDR_CTL, 8'h87);
    rdchk(CAC_ADDR_CTL, 8'h87);
    chk_bit("irq", 1'b0, irq);
    wr(CAC_ADDR_MODE, 8'h01);
    chk_bit("irq", 1'b1, irq);
    wr(8'ha5, 8'hff);
    bw(7, 1'b0);
    bw(4, 1'b0);
    rdchk(CAC_ADDR_CTL, 8'h07);
    chk_bit("irq", 1'b0, irq);
    wr(CAC_ADDR_CTL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      module_event_irq_enable = 3'h1 << i;
      module_event = 3'h1 << i;
      step(1);
      module_event = 3'h0;
      step(3);
      chk_bit("irq", 1'b1, irq);
      rdchk(CAC_ADDR_CTL, 8'h01 << i);
      bw(i, 1'b0);
      chk_bit("irq", 1'b0, irq);
    end
    module_event_irq_enable = 3'h0;
    // Hardware set beats a software clear in the same cycle
    module_event = 3'h1;
    sfr_addr     = CAC_ADDR_CTL;
    sfr_wdata    = 8'h00;
    sfr_wr       = 1'b1;
    step(1);
    module_event = 3'h0;
    sfr_wr       = 1'b0;
    step(1);
    rdchk(CAC_ADDR_CTL, 8'h01);
    wr(CAC_ADDR_CTL, 8'h00);
  endtask

  // Every timebase code over a 72-cycle window
  task automatic t_tb;
    logic [15:0] v0;
    int          ex [8] = '{6, 18, 16, 16, 72, 2, 2, 0};
    for (int c = 0; c < 8; c++) begin
      wr(CAC_ADDR_MODE, {4'h0, c[2:0], 1'b0});
      bw(CAC_CTL_RUN, 1'b1);
      step(2);
      v0 = counter_value;
      for (int i = 0; i < 72; i++) begin
        timer0_ovf = (i < 64) && (i[1:0] == 2'h0);
        external_count_input = (i < 64) && i[1];
        ext_clk_in = (i < 64) && i[1];
        lfo_clk_in = (i < 64) && i[1];
        step(1);
      end
      chk("tick_count", 16'(v0 + ex[c]), counter_value);
      bw(CAC_CTL_RUN, 1'b0);
    end
  endtask

  // Idle suspension and run hold
  task automatic t_idle;
    logic [15:0] v0;
    wr(CAC_ADDR_MODE, 8'h88);
    cpu_idle = 1'b1;
    bw(CAC_CTL_RUN, 1'b1);
    v0 = counter_value;
    step(10);
    chk("idle_hold", v0, counter_value);
    wr(CAC_ADDR_MODE, 8'h08);
    v0 = counter_value;
    step(10);
    chk("idle_run", 16'(v0 + 16'd10), counter_value);
    cpu_idle = 1'b0;
    bw(CAC_CTL_RUN, 1'b0);
    v0 = counter_value;
    step(5);
    chk("stop_hold", v0, counter_value);
  endtask

  // Cycle wrap point for length codes 000 to 011, no wrap for reserved code 100
  task automatic t_wrap;
    logic [15:0] v0;
    for (int c = 0; c < 5; c++) begin
      wr(CAC_ADDR_PWM, 8'h40 | c[7:0]);
      v0 = counter_value;
      bw(CAC_CTL_RUN, 1'b1);
      if (c < 4) begin
        wait_irq(2100);
        chk("wrap_point", 16'(((v0 >> (8 + c)) + 1) << (8 + c)), counter_value);
      end else begin
        step(2100);
        chk_bit("irq", 1'b0, irq);
      end
      bw(CAC_CTL_RUN, 1'b0);
    end
    wr(CAC_ADDR_PWM, 8'h00);
  endtask

  // Full counter rollover and sticky overflow flag
  task automatic t_ovf;
    wr(CAC_ADDR_MODE, 8'h09);
    wr(CAC_ADDR_CTL, 8'h40);
    wait_irq(70000);
    chk("rollover", 16'h0000, counter_value);
    bw(CAC_CTL_RUN, 1'b0);
    step(3);
    chk_bit("irq", 1'b1, irq);
    rdchk(CAC_ADDR_CTL, 8'h80);
    wr(CAC_ADDR_MODE, 8'h08);
    chk_bit("irq", 1'b0, irq);
    wr(CAC_ADDR_MODE, 8'h09);
    bw(CAC_CTL_OVF, 1'b0);
    chk_bit("irq", 1'b0, irq);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    t_regs();
    t_tb();
    t_idle();
    t_wrap();
    t_ovf();
    final_report();
  end
endmodule
